// File: verilog/aid_pkg.sv
// constants for the add/subtract/increment instruction decoder
// assumes a 16-bit instruction word and 4-bit data memory
package aid_pkg;
    // instruction field positions
    localparam int OPC_MSB  = 15;
    localparam int OPC_LSB  = 11;
    localparam int ROW_MSB  = 10;
    localparam int ROW_LSB  = 8;
    localparam int COL_MSB  = 7;
    localparam int COL_LSB  = 4;
    localparam int LOW_MSB  = 3;
    localparam int LOW_LSB  = 0;
    localparam int ADDR_MSB = 10;
    localparam int ADDR_W   = 11;
    localparam int PAGE_W   = 2;
    localparam int NIB_W    = 4;
    localparam int ROW_W    = 3;
    localparam int MADDR_W  = 7;
    // opcodes
    localparam logic [4:0] OP_ADD_REG  = 5'h00;
    localparam logic [4:0] OP_SUB_REG  = 5'h01;
    localparam logic [4:0] OP_CARRY_SUM_OP_REG = 5'h02;
    localparam logic [4:0] OP_BORROW_DIFFERENCE_OP_REG = 5'h03;
    localparam logic [4:0] OP_ADD_IMM  = 5'h10;
    localparam logic [4:0] OP_SUB_IMM  = 5'h11;
    localparam logic [4:0] OP_CARRY_SUM_OP_IMM = 5'h12;
    localparam logic [4:0] OP_BORROW_DIFFERENCE_OP_IMM = 5'h13;
    localparam logic [2:0] OP_BR_HEAD  = 3'h3;
    // fixed increment words
    localparam logic [15:0] INC_AR_WORD = 16'h3890;
    localparam logic [15:0] INC_IX_WORD = 16'h3880;
    // reset values
    localparam logic [3:0] NIB_RST = 4'h0;
    typedef enum logic {ST_FETCH, ST_EXEC} aid_state_type;
endpackage

// File: verilog/aid_decoder.sv
// add/subtract/increment decoder and executor, plus operand field split
// assumes synchronous program memory handshake and one-cycle data memory read
`timescale 1ns/1ps
// Overview of operation
// - 00000 adds memory to register; 10000 adds immediate to memory.
// - 00010 adds register, memory and carry into register.
// - 10010 adds memory, immediate and carry back into memory.
// - fixed word 00111 000 1001 0000 increments the address pointer.
// - fixed word 00111 000 1000 0000 increments the index pointer.
// - 00001 subtracts memory from register into register.
// - 10001 subtracts immediate from memory back into memory.
// - 00011 subtracts memory and carry from register into register.
// - memory address is row field high, column field low.
// - branch target field gives the low 11 program address bits.
// - page sits in program counter bits 11 and 12.
// - low field is a 4-bit immediate or a 4-bit bit mask.
// - peripheral address splits into 3-bit upper and 4-bit lower parts.
// - register-file address splits into 3-bit row and 4-bit column.
// - interrupt acceptance pushes the context word with no instruction.
module aid_decoder #(
    parameter int AR_W = 16,
    parameter int IX_W = 11
) (
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    input  wire logic                       clk_en,
    input  wire logic                       instr_valid,
    input  wire logic [15:0]                instr_word,
    input  wire logic [3:0]                 mem_rdata,
    input  wire logic                       int_accept,
    output logic                            instr_ready,
    output logic [aid_pkg::MADDR_W-1:0]     mem_addr,
    output logic                            mem_rd_en,
    output logic                            mem_wr_en,
    output logic [3:0]                      mem_wdata,
    output logic [3:0]                      result_nibble,
    output logic                            result_valid,
    output logic                            carry_flag,
    output logic [AR_W-1:0]                 address_pointer,
    output logic [IX_W-1:0]                 index_pointer,
    output logic [3:0]                      immediate_nibble,
    output logic [3:0]                      bit_mask,
    output logic [2:0]                      peripheral_address_upper,
    output logic [3:0]                      peripheral_address_lower,
    output logic [2:0]                      regfile_row_field,
    output logic [3:0]                      regfile_col_field,
    output logic [12:0]                     branch_target,
    output logic                            branch_valid,
    output logic                            int_stack_push,
    output logic [3:0]                      interrupt_context_word
);
    if (AR_W < 1 || IX_W < 1) begin : bad_width
        $error("pointer widths must be positive");
    end

    function automatic logic [4:0] alu(input logic [3:0] a, input logic [3:0] b,
                                       input logic cin, input logic sub);
        logic [4:0] r;
        r = 5'h00;
        if (sub) r = {1'b0, a} - {1'b0, b} - {4'h0, cin};
        else     r = {1'b0, a} + {1'b0, b} + {4'h0, cin};
        return r;
    endfunction

    aid_pkg::aid_state_type state;
    aid_pkg::aid_state_type next_state;
    logic [3:0] gen_reg [0:15];
    logic [4:0] op_q;
    logic [3:0] low_q;

    wire logic [4:0] opcode = instr_word[aid_pkg::OPC_MSB:aid_pkg::OPC_LSB];
    wire logic [2:0] memory_row_field = instr_word[aid_pkg::ROW_MSB:aid_pkg::ROW_LSB];
    wire logic [3:0] memory_column_field = instr_word[aid_pkg::COL_MSB:aid_pkg::COL_LSB];
    wire logic [3:0] low_field = instr_word[aid_pkg::LOW_MSB:aid_pkg::LOW_LSB];
    wire logic accept = clk_en && instr_valid && state == aid_pkg::ST_FETCH;
    wire logic arith_op = opcode[3:2] == 2'b00;
    wire logic is_inc_ar = instr_word == aid_pkg::INC_AR_WORD;
    wire logic is_inc_ix = instr_word == aid_pkg::INC_IX_WORD;
    wire logic is_branch = opcode[4:2] == aid_pkg::OP_BR_HEAD;
    wire logic exec_fire = clk_en && state == aid_pkg::ST_EXEC;
    wire logic reg_form = ~op_q[4];
    wire logic [3:0] alu_a = reg_form ? gen_reg[low_q] : mem_rdata;
    wire logic [3:0] alu_b = reg_form ? mem_rdata : low_q;
    wire logic alu_cin = op_q[1] & carry_flag;
    wire logic [4:0] alu_out = alu(alu_a, alu_b, alu_cin, op_q[0]);

    always_comb begin
        next_state = state;
        case (state)
            aid_pkg::ST_FETCH: if (accept && arith_op) next_state = aid_pkg::ST_EXEC;
            aid_pkg::ST_EXEC:  next_state = aid_pkg::ST_FETCH;
            default:           next_state = aid_pkg::ST_FETCH;
        endcase
    end

    // fetch side: state, field split, pointer increments
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state                    <= aid_pkg::ST_FETCH;
            instr_ready              <= 1'b1;
            op_q                     <= 5'h00;
            low_q                    <= aid_pkg::NIB_RST;
            mem_addr                 <= '0;
            mem_rd_en                <= 1'b0;
            address_pointer          <= '0;
            index_pointer            <= '0;
            immediate_nibble         <= aid_pkg::NIB_RST;
            bit_mask                 <= aid_pkg::NIB_RST;
            peripheral_address_upper <= 3'h0;
            peripheral_address_lower <= aid_pkg::NIB_RST;
            regfile_row_field        <= 3'h0;
            regfile_col_field        <= aid_pkg::NIB_RST;
            branch_target            <= 13'h0000;
            branch_valid             <= 1'b0;
        end else if (clk_en) begin
            state       <= next_state;
            instr_ready <= next_state == aid_pkg::ST_FETCH;
            mem_rd_en   <= accept && arith_op;
            branch_valid <= accept && is_branch;
            if (accept) begin
                op_q                     <= opcode;
                low_q                    <= low_field;
                mem_addr                 <= {memory_row_field, memory_column_field};
                immediate_nibble         <= low_field;
                bit_mask                 <= low_field;
                peripheral_address_upper <= memory_row_field;
                peripheral_address_lower <= low_field;
                regfile_row_field        <= memory_row_field;
                regfile_col_field        <= low_field;
                if (is_branch)
                    branch_target <= {opcode[1:0], instr_word[aid_pkg::ADDR_MSB:0]};
                if (is_inc_ar) address_pointer <= address_pointer + 1'b1;
                if (is_inc_ix) index_pointer <= index_pointer + 1'b1;
            end
        end
    end

    // execute side: write-back, carry, interrupt context push
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mem_wr_en              <= 1'b0;
            mem_wdata              <= aid_pkg::NIB_RST;
            result_nibble          <= aid_pkg::NIB_RST;
            result_valid           <= 1'b0;
            carry_flag             <= 1'b0;
            int_stack_push         <= 1'b0;
            interrupt_context_word <= aid_pkg::NIB_RST;
            for (int i = 0; i < 16; i++) gen_reg[i] <= aid_pkg::NIB_RST;
        end else if (clk_en) begin
            mem_wr_en      <= exec_fire && ~reg_form;
            result_valid   <= exec_fire;
            int_stack_push <= int_accept;
            if (int_accept) interrupt_context_word <= {3'h0, carry_flag};
            if (exec_fire) begin
                result_nibble <= alu_out[3:0];
                carry_flag    <= alu_out[4];
                if (reg_form) gen_reg[low_q] <= alu_out[3:0];
                else          mem_wdata <= alu_out[3:0];
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    add_imm_a: assert property (exec_fire && op_q == aid_pkg::OP_ADD_IMM |=>
        mem_wr_en && mem_wdata == 4'($past(mem_rdata) + $past(low_q)))
        else $error("immediate add result wrong");
    carry_sum_op_reg_a: assert property (exec_fire && op_q == aid_pkg::OP_CARRY_SUM_OP_REG |=>
        result_nibble == 4'($past(alu_a) + $past(mem_rdata) + $past(carry_flag)))
        else $error("register carry add wrong");
    carry_sum_op_imm_a: assert property (exec_fire && op_q == aid_pkg::OP_CARRY_SUM_OP_IMM |=>
        mem_wdata == 4'($past(mem_rdata) + $past(low_q) + $past(carry_flag)))
        else $error("immediate carry add wrong");
    inc_ar_a: assert property (accept && is_inc_ar |=>
        address_pointer == AR_W'($past(address_pointer) + 1))
        else $error("address pointer not incremented");
    inc_ix_a: assert property (accept && is_inc_ix |=>
        index_pointer == IX_W'($past(index_pointer) + 1))
        else $error("index pointer not incremented");
    sub_reg_a: assert property (exec_fire && op_q == aid_pkg::OP_SUB_REG |=>
        !mem_wr_en && carry_flag == ($past(alu_a) < $past(mem_rdata)))
        else $error("register subtract borrow wrong");
    sub_imm_a: assert property (exec_fire && op_q == aid_pkg::OP_SUB_IMM |=>
        mem_wdata == 4'($past(mem_rdata) - $past(low_q)))
        else $error("immediate subtract wrong");
    borrow_difference_op_reg_a: assert property (exec_fire && op_q == aid_pkg::OP_BORROW_DIFFERENCE_OP_REG |=>
        result_nibble == 4'($past(alu_a) - $past(mem_rdata) - $past(carry_flag)))
        else $error("register borrow subtract wrong");
    mem_addr_a: assert property (accept && arith_op |=>
        mem_rd_en && mem_addr == $past(instr_word[aid_pkg::ROW_MSB:aid_pkg::COL_LSB]))
        else $error("memory address split wrong");
    branch_a: assert property (accept && is_branch |=>
        branch_valid && branch_target[aid_pkg::ADDR_MSB:0] == $past(instr_word[10:0]))
        else $error("branch target wrong");
    int_push_a: assert property (clk_en && int_accept |=>
        int_stack_push && interrupt_context_word[0] == $past(carry_flag))
        else $error("context word not pushed");
    add_reg_a: assert property (exec_fire && op_q == aid_pkg::OP_ADD_REG |=>
        !mem_wr_en && result_nibble == 4'($past(alu_a) + $past(mem_rdata)))
        else $error("register add result wrong");
    ready_gap_a: assert property (accept && arith_op |=>
        !instr_ready && state == aid_pkg::ST_EXEC)
        else $error("word taken during execute cycle");
    fields_a: assert property (accept |=>
        immediate_nibble == $past(low_field) && regfile_row_field == $past(memory_row_field))
        else $error("operand field split wrong");
    page_a: assert property (accept && is_branch |=>
        branch_target[aid_pkg::ADDR_W +: aid_pkg::PAGE_W] == $past(opcode[1:0]))
        else $error("branch page wrong");
    borrow_difference_op_imm_a: assert property (exec_fire && op_q == aid_pkg::OP_BORROW_DIFFERENCE_OP_IMM |=>
        mem_wdata == 4'($past(mem_rdata) - $past(low_q) - $past(carry_flag)))
        else $error("immediate borrow subtract wrong");
    freeze_a: assert property (!clk_en |=>
        $stable(state) && $stable(carry_flag) && $stable(mem_rd_en) && $stable(result_valid))
        else $error("state moved while enable low");
    push_once_a: assert property (clk_en && !int_accept |=>
        !int_stack_push)
        else $error("context push without interrupt");

    add_seen_c: cover property (exec_fire && op_q == aid_pkg::OP_ADD_REG);
    borrow_difference_op_seen_c: cover property (exec_fire && op_q == aid_pkg::OP_BORROW_DIFFERENCE_OP_REG && carry_flag);
    inc_seen_c: cover property (accept && is_inc_ar ##[1:4] accept && is_inc_ix);
    freeze_seen_c: cover property (!clk_en && state == aid_pkg::ST_EXEC);
    int_seen_c: cover property (int_accept && exec_fire);
endmodule

// File: tb/aid_prog_mem.sv
// program memory model: presents one instruction word per request
// assumes the decoder takes a word on an enabled edge with ready high
`timescale 1ns/1ps
module aid_prog_mem (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        req,
    input  wire logic [15:0] req_word,
    input  wire logic        instr_ready,
    output logic             instr_valid = 1'b0,
    output logic [15:0]      instr_word = 16'hFFFF,
    output logic             taken = 1'b0
);
    // word held until taken, then the line shows the inverse of the last word
    always @(posedge clk_sys) begin
        taken <= 1'b0;
        if (sys_rst) begin
            instr_valid <= 1'b0;
        end else if (instr_valid && clk_en && instr_ready) begin
            instr_valid <= 1'b0;
            instr_word  <= ~instr_word;
            taken       <= 1'b1;
        end else if (req && !instr_valid) begin
            instr_valid <= 1'b1;
            instr_word  <= req_word;
        end
    end
endmodule

// File: tb/arith_instruction_decoder_tb.sv
// self-checking bench for the add/subtract/increment decoder
// assumes data memory is modelled here and program memory by aid_prog_mem
`timescale 1ns/1ps
module arith_instruction_decoder_tb;
    logic clk_sys = 0, sys_rst = 1, clk_en = 1, req = 0, int_accept = 0;
    logic instr_valid, instr_ready, taken, mem_rd_en, mem_wr_en, result_valid;
    logic carry_flag, branch_valid, int_stack_push, cy;
    logic [15:0] req_word = 16'h0000, instr_word, ar;
    logic [3:0]  mem_rdata = 4'h0, mem_wdata, result_nibble, imm, bm, pl, rc, icw;
    logic [2:0]  ph, rr;
    logic [6:0]  mem_addr;
    logic [10:0] ix;
    logic [12:0] bt;
    logic [3:0]  mem [128];
    logic [3:0]  regs [16];
    logic [4:0]  ops [8] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h12, 5'h13};
    int          n_fail = 0, num_checks = 0;
    aid_prog_mem pm (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en), .req(req),
        .req_word(req_word), .instr_ready(instr_ready), .instr_valid(instr_valid),
        .instr_word(instr_word), .taken(taken));
    aid_decoder DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
        .instr_valid(instr_valid), .instr_word(instr_word), .mem_rdata(mem_rdata),
        .int_accept(int_accept), .instr_ready(instr_ready), .mem_addr(mem_addr),
        .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
        .result_nibble(result_nibble), .result_valid(result_valid),
        .carry_flag(carry_flag), .address_pointer(ar), .index_pointer(ix),
        .immediate_nibble(imm), .bit_mask(bm), .peripheral_address_upper(ph),
        .peripheral_address_lower(pl), .regfile_row_field(rr), .regfile_col_field(rc),
        .branch_target(bt), .branch_valid(branch_valid), .int_stack_push(int_stack_push),
        .interrupt_context_word(icw));
    initial begin
        forever #20 clk_sys = ~clk_sys;
    end
    // data memory: write on pulse, read data valid from 1 ns after the edge that raises the read pulse
    always @(posedge clk_sys) if (mem_wr_en && clk_en) mem[mem_addr] <= mem_wdata;
    always @(posedge clk_sys) begin
        #1;
        mem_rdata = mem_rd_en ? mem[mem_addr] : ~mem_rdata;
    end
    function automatic logic [4:0] calc(logic [4:0] op, logic [3:0] a, logic [3:0] b, logic c);
        logic ci;
        ci = op[1] & c;
        return op[0] ? {1'b0, a} - {1'b0, b} - {4'h0, ci} : {1'b0, a} + {1'b0, b} + {4'h0, ci};
    endfunction
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic issue(logic [15:0] w);
        int k;
        k = 0;
        @(posedge clk_sys); #1;
        req = 1;
        req_word = w;
        @(posedge clk_sys); #1;
        req = 0;
        while (taken !== 1'b1 && k < 20) begin
            @(posedge clk_sys); #1;
            k++;
        end
        chk("taken", 16'h1, {15'h0, taken});
        chk("mem_addr", {9'h0, w[10:4]}, {9'h0, mem_addr});
        chk("imm", {12'h0, w[3:0]}, {12'h0, imm});
        chk("mask", {12'h0, w[3:0]}, {12'h0, bm});
        chk("periph", {9'h0, w[10:8], w[3:0]}, {9'h0, ph, pl});
        chk("regfile", {9'h0, w[10:8], w[3:0]}, {9'h0, rr, rc});
    endtask
    task automatic arith(logic [15:0] w, int stall, logic irq);
        logic [4:0] op, e;
        logic [3:0] m;
        op = w[15:11];
        issue(w);
        m = mem[w[10:4]];
        e = calc(op, op[4] ? m : regs[w[3:0]], op[4] ? w[3:0] : m, cy);
        chk("rd_en", 16'h1, {15'h0, mem_rd_en});
        repeat (stall) begin
            clk_en = 0;
            @(posedge clk_sys); #1;
            chk("frozen", 16'h1, {15'h0, mem_rd_en & ~result_valid});
        end
        clk_en = 1;
        int_accept = irq;
        @(posedge clk_sys); #1;
        int_accept = 0;
        chk("push_exec", {15'h0, irq}, {15'h0, int_stack_push});
        if (irq) chk("ctx_exec", {15'h0, cy}, {12'h0, icw});
        chk("res_valid", 16'h1, {15'h0, result_valid});
        chk("result", {12'h0, e[3:0]}, {12'h0, result_nibble});
        chk("carry", {15'h0, e[4]}, {15'h0, carry_flag});
        chk("wr_en", {15'h0, op[4]}, {15'h0, mem_wr_en});
        if (op[4]) chk("wdata", {12'h0, e[3:0]}, {12'h0, mem_wdata});
        else regs[w[3:0]] = e[3:0];
        cy = e[4];
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end
    initial begin
        logic [15:0] v, w;
        void'($urandom(32'h14375424));
        cy = 0;
        foreach (mem[i]) mem[i] = 4'($urandom);
        foreach (regs[i]) regs[i] = 4'h0;
        repeat (4) @(posedge clk_sys);
        #1;
        sys_rst = 0;
        chk("ready", 16'h1, {15'h0, instr_ready});
        mem[7'h00] = 4'hF;
        arith(16'h800F, 0, 1'b0);
        arith(16'h9001, 1, 1'b1);
        arith(16'h1005, 0, 1'b0);
        arith(16'h1805, 2, 1'b0);
        for (int i = 0; i < 60; i++) begin
            arith({ops[$urandom % 8], 11'($urandom)}, $urandom % 3, 1'($urandom));
        end
        for (int i = 0; i < 2; i++) begin
            v = ar;
            issue(16'h3890);
            chk("addr_ptr", v + 16'h1, ar);
            v = {5'h0, ix};
            issue(16'h3880);
            chk("index_ptr", {5'h0, 11'(v + 16'h1)}, {5'h0, ix});
        end
        for (int p = 0; p < 4; p++) begin
            w = {3'b011, 2'(p), 11'($urandom)};
            issue(w);
            chk("br_valid", 16'h1, {15'h0, branch_valid});
            chk("target", {3'h0, 2'(p), w[10:0]}, {3'h0, bt});
        end
        @(posedge clk_sys); #1;
        int_accept = 1;
        @(posedge clk_sys); #1;
        int_accept = 0;
        chk("push", 16'h1, {15'h0, int_stack_push});
        chk("context", {15'h0, cy}, {12'h0, icw});
        close_out();
    end
endmodule
